// ### logic/ahi_adc_host_interface.sv
module ahi_adc_host_interface
    import ahi_pkg::*;
(
    // system clock domain
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic             clk_en,
    // conversion clock pin and sampled code from the converter core
    input  wire logic             conv_clk,
    input  wire logic [RES_W-1:0] conv_sample,
    // host pins, asynchronous
    input  wire ahi_host_t        host_pins,
    // three-state data pins
    output ahi_pins_t             pins,
    // status
    output logic                  busy,
    output logic [RES_W-1:0]      result
);

    // host pin synchronisers, system domain
    ahi_host_t host_m_reg;
    ahi_host_t host_s_reg;
    ahi_host_t host_d_reg;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            host_m_reg <= '1;
            host_s_reg <= '1;
            host_d_reg <= '1;
        end else if (clk_en) begin
            host_m_reg <= host_pins;
            host_s_reg <= host_m_reg;
            host_d_reg <= host_s_reg;
        end
    end

    wire logic par_mode    = host_s_reg.output_mode_select;
    wire logic cs_act      = !host_s_reg.cs_n;
    wire logic rd_act      = cs_act && !host_s_reg.rd_n;
    wire logic hbs         = host_s_reg.high_byte_select;
    wire logic par_cond    = rd_act && !hbs;
    wire logic par_cond_d  = !host_d_reg.cs_n && !host_d_reg.rd_n && !host_d_reg.high_byte_select;
    wire logic cs_fall     = cs_act && host_d_reg.cs_n;
    wire logic start_cond  = par_mode ? (par_cond && !par_cond_d) : (cs_fall && !hbs);

    // handshake with the conversion domain
    logic             pend_reg;
    logic             req_tgl_reg;
    logic             done_m_reg;
    logic             done_s_reg;
    logic             done_d_reg;
    logic [RES_W-1:0] result_reg;
    logic [RES_W-1:0] word_reg;
    logic             done_tgl_reg;

    // a start while one is still running is dropped; the core cannot restart mid-word
    wire logic start   = start_cond && !pend_reg;
    wire logic done_ev = done_s_reg ^ done_d_reg;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pend_reg    <= 1'b0;
            req_tgl_reg <= 1'b0;
            done_m_reg  <= 1'b0;
            done_s_reg  <= 1'b0;
            done_d_reg  <= 1'b0;
            result_reg  <= RESULT_RST;
        end else if (clk_en) begin
            done_m_reg <= done_tgl_reg;
            done_s_reg <= done_m_reg;
            done_d_reg <= done_s_reg;
            if (start) begin
                pend_reg    <= 1'b1;
                req_tgl_reg <= !req_tgl_reg;
            end else if (done_ev) begin
                pend_reg <= 1'b0;
            end
            // word stays stable from its done toggle until the next start
            if (done_ev) begin
                result_reg <= word_reg;
            end
        end
    end

    // pin drive, system domain
    logic [PIN_W-1:0] par_out_reg;
    logic [PIN_W-1:0] oe_reg;
    logic             mode_reg;

    wire logic [PIN_W-1:0] par_data = hbs ? {MSB_PAD, result_reg[RES_W-1:LSB_W]}
                                          : result_reg[LSB_W-1:0];
    wire logic [PIN_W-1:0] ser_oe   = rd_act ? OE_SERIAL : OE_SDOUT;
    wire logic [PIN_W-1:0] oe_next  = !cs_act  ? PINS_RST :
                                      par_mode ? (rd_act ? OE_ALL : PINS_RST) :
                                                 ser_oe;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            par_out_reg <= PINS_RST;
            oe_reg      <= PINS_RST;
            mode_reg    <= 1'b1;
        end else if (clk_en) begin
            par_out_reg <= par_data;
            oe_reg      <= oe_next;
            mode_reg    <= par_mode;
        end
    end

    // conversion domain, clocked by the conversion clock pin
    logic             lrst_m_reg;
    logic             link_rst;

    always_ff @(posedge conv_clk or posedge reset) begin
        if (reset) begin
            lrst_m_reg <= 1'b1;
            link_rst   <= 1'b1;
        end else begin
            lrst_m_reg <= 1'b0;
            link_rst   <= lrst_m_reg;
        end
    end

    // levels and the request toggle cross on two flops each
    logic [3:0]       lsync_m_reg;
    logic [3:0]       lsync_s_reg;
    logic             lreq_d_reg;

    always_ff @(posedge conv_clk or posedge link_rst) begin
        if (link_rst) begin
            lsync_m_reg <= 4'h0;
            lsync_s_reg <= 4'h0;
        end else begin
            lsync_m_reg <= {clk_en, req_tgl_reg, cs_act, hbs};
            lsync_s_reg <= lsync_m_reg;
        end
    end

    wire logic l_en   = lsync_s_reg[3];
    wire logic l_req  = lsync_s_reg[2];
    wire logic l_cs   = lsync_s_reg[1];
    wire logic l_hbs  = lsync_s_reg[0];
    wire logic l_go   = l_req ^ lreq_d_reg;

    ahi_lstate_t      lstate_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic [RES_W-1:0] shift_reg;
    logic             sclk_reg;
    logic             sdout_reg;
    logic             strobe_reg;

    wire logic l_busy = (lstate_reg == L_CONV);
    wire logic l_run  = l_cs && (l_hbs || l_busy);

    always_ff @(posedge conv_clk or posedge link_rst) begin
        if (link_rst) begin
            lreq_d_reg   <= 1'b0;
            lstate_reg   <= L_IDLE;
            cnt_reg      <= 4'h0;
            shift_reg    <= RESULT_RST;
            word_reg     <= RESULT_RST;
            sclk_reg     <= 1'b0;
            sdout_reg    <= 1'b0;
            strobe_reg   <= 1'b0;
            done_tgl_reg <= 1'b0;
        end else if (l_en) begin
            lreq_d_reg <= l_req;
            strobe_reg <= 1'b0;
            if (l_run) begin
                sclk_reg <= !sclk_reg;
            end
            case (lstate_reg)
                L_IDLE: begin
                    if (l_go) begin
                        lstate_reg <= L_CONV;
                        shift_reg  <= conv_sample;
                        word_reg   <= conv_sample;
                        cnt_reg    <= 4'h0;
                    end
                end
                L_CONV: begin
                    sdout_reg <= shift_reg[RES_W-1];
                    shift_reg <= {shift_reg[RES_W-2:0], 1'b0};
                    cnt_reg   <= cnt_reg + 4'h1;
                    if (cnt_reg == CONV_LAST) begin
                        lstate_reg   <= L_IDLE;
                        strobe_reg   <= 1'b1;
                        done_tgl_reg <= !done_tgl_reg;
                    end
                end
                default: lstate_reg <= L_IDLE;
            endcase
        end
    end

    // serial roles take over pins 5..7; the rest keep the parallel word
    // mode comes from the flop beside the enables, so a mode change never mixes roles
    wire logic [PIN_W-1:0] pin_out = mode_reg ? par_out_reg :
                                     {sdout_reg, sclk_reg, strobe_reg, par_out_reg[PIN_STROBE-1:0]};

    assign pins.out = pin_out;
    assign pins.oe  = oe_reg;
    assign busy     = pend_reg;
    assign result   = result_reg;

    // checks, system domain
    sequence s_par_read;
        par_mode && rd_act;
    endsequence

    property p_par_float;
        @(posedge clk) disable iff (reset)
        (clk_en && par_mode && !rd_act) |=> (oe_reg == PINS_RST);
    endproperty
    a_par_float: assert property (p_par_float) else $error("parallel pins driven without read");

    property p_par_msb;
        @(posedge clk) disable iff (reset)
        (clk_en && hbs && !done_ev) ##0 s_par_read |=>
            (pins.oe == OE_ALL) && (pins.out == {MSB_PAD, result[RES_W-1:LSB_W]});
    endproperty
    a_par_msb: assert property (p_par_msb) else $error("high byte not on lower pins");

    property p_par_lsb;
        @(posedge clk) disable iff (reset)
        (clk_en && !hbs && !done_ev) ##0 s_par_read |=> (pins.out == result[LSB_W-1:0]);
    endproperty
    a_par_lsb: assert property (p_par_lsb) else $error("low byte not on data pins");

    property p_hbs_no_start;
        @(posedge clk) disable iff (reset)
        hbs |-> !start;
    endproperty
    a_hbs_no_start: assert property (p_hbs_no_start) else $error("start with high-byte select high");

    property p_cs_idle;
        @(posedge clk) disable iff (reset)
        (clk_en && !cs_act) |-> !start ##1 (pins.oe == PINS_RST);
    endproperty
    a_cs_idle: assert property (p_cs_idle) else $error("outputs or start with chip select high");

    property p_par_start;
        @(posedge clk) disable iff (reset)
        (clk_en && par_mode && par_cond && !par_cond_d && !pend_reg) |=> pend_reg && $changed(req_tgl_reg);
    endproperty
    a_par_start: assert property (p_par_start) else $error("parallel read did not start");

    property p_ser_start;
        @(posedge clk) disable iff (reset)
        (clk_en && !par_mode && cs_fall && !hbs && !pend_reg) |=> pend_reg ##0 $changed(req_tgl_reg);
    endproperty
    a_ser_start: assert property (p_ser_start) else $error("chip select fall did not start");

    property p_ser_rd_high;
        @(posedge clk) disable iff (reset)
        (clk_en && !par_mode && cs_act && !rd_act) |=> (oe_reg == OE_SDOUT);
    endproperty
    a_ser_rd_high: assert property (p_ser_rd_high) else $error("serial clock or strobe driven");

    property p_ser_drive;
        @(posedge clk) disable iff (reset)
        (clk_en && !par_mode && rd_act) |=> (oe_reg == OE_SERIAL);
    endproperty
    a_ser_drive: assert property (p_ser_drive) else $error("serial pins not driven");

    property p_ser_cs_high;
        @(posedge clk) disable iff (reset)
        (clk_en && !par_mode && !cs_act) |=> (oe_reg == PINS_RST);
    endproperty
    a_ser_cs_high: assert property (p_ser_cs_high) else $error("serial pins driven with chip select high");

    property p_ser_roles;
        @(posedge clk) disable iff (reset)
        (clk_en && !par_mode) |=>
            (pins.oe[PIN_STROBE-1:0] == PINS_RST[PIN_STROBE-1:0]) && (pins.out[PIN_SDOUT] == sdout_reg);
    endproperty
    a_ser_roles: assert property (p_ser_roles) else $error("serial pin roles not applied");

    // checks, conversion domain
    property p_sclk_hold;
        @(posedge conv_clk) disable iff (link_rst)
        (l_en && !l_hbs && !l_busy) |=> $stable(sclk_reg);
    endproperty
    a_sclk_hold: assert property (p_sclk_hold) else $error("serial clock toggled while idle");

    property p_sclk_run;
        @(posedge conv_clk) disable iff (link_rst)
        (l_en && l_hbs && l_cs) |=> (sclk_reg != $past(sclk_reg));
    endproperty
    a_sclk_run: assert property (p_sclk_run) else $error("serial clock not free running");

endmodule : ahi_adc_host_interface

// ### logic/ahi_pkg.sv
package ahi_pkg;

    // conversion word layout
    localparam int RES_W  = 12;
    localparam int LSB_W  = 8;
    localparam int MSB_W  = 4;
    localparam int PIN_W  = 8;
    localparam int CNT_W  = 4;

    // serial role of the upper data pins
    localparam int PIN_STROBE = 5;
    localparam int PIN_SCLK   = 6;
    localparam int PIN_SDOUT  = 7;

    // count of the last bit of a conversion, counted in conversion clocks
    localparam logic [CNT_W-1:0] CONV_LAST = 4'hB;

    // values after reset, pin enable patterns and the high-nibble pad
    localparam logic [RES_W-1:0] RESULT_RST = 12'h000;
    localparam logic [PIN_W-1:0] PINS_RST   = 8'h00;
    localparam logic [PIN_W-1:0] OE_ALL     = 8'hFF;
    localparam logic [PIN_W-1:0] OE_SERIAL  = 8'hE0;
    localparam logic [PIN_W-1:0] OE_SDOUT   = 8'h80;
    localparam logic [MSB_W-1:0] MSB_PAD    = 4'h0;

    // host-side pins, sampled together
    typedef struct packed {
        logic output_mode_select;
        logic high_byte_select;
        logic cs_n;
        logic rd_n;
    } ahi_host_t;

    // three-state data pin bundle
    typedef struct packed {
        logic [PIN_W-1:0] out;
        logic [PIN_W-1:0] oe;
    } ahi_pins_t;

    typedef enum logic {L_IDLE, L_CONV} ahi_lstate_t;

endpackage : ahi_pkg

// ### dv/ahi_serial_host.sv
module ahi_serial_host
    import ahi_pkg::*;
(
    // link side
    output logic             conv_clk,
    input  wire logic        reset,
    input  wire ahi_pins_t   pins,
    // last word taken off the serial pins
    output logic [RES_W-1:0] word
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [RES_W-1:0] shift_reg;

    // converter clock runs free and doubles as the serial clock input
    initial begin
        conv_clk = 1'b0;
        #7;
        forever #16 conv_clk = ~conv_clk;
    end

    // a floating data pin is never shifted in; the strobe closes the word
    always_ff @(posedge conv_clk or posedge reset) begin
        if (reset) begin
            shift_reg <= RESULT_RST;
            word      <= RESULT_RST;
        end else if (pins.oe[PIN_SDOUT]) begin
            shift_reg <= {shift_reg[RES_W-2:0], pins.out[PIN_SDOUT]};
            if (pins.oe[PIN_STROBE] && pins.out[PIN_STROBE]) begin
                word <= {shift_reg[RES_W-2:0], pins.out[PIN_SDOUT]};
            end
        end
    end
endmodule : ahi_serial_host

// ### dv/tb_adc_host_interface.sv
module tb_adc_host_interface
    import ahi_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic             clk;
    logic             reset;
    logic             clk_en;
    logic             conv_clk;
    logic [RES_W-1:0] conv_sample;
    ahi_host_t        host_pins;
    ahi_pins_t        pins;
    logic             busy;
    logic [RES_W-1:0] result;
    logic [RES_W-1:0] word;
    int               fails;
    int               check_count;
    int               edges;

    ahi_adc_host_interface u_dut (
        .clk         (clk),
        .reset       (reset),
        .clk_en      (clk_en),
        .conv_clk    (conv_clk),
        .conv_sample (conv_sample),
        .host_pins   (host_pins),
        .pins        (pins),
        .busy        (busy),
        .result      (result)
    );

    ahi_serial_host u_host (
        .conv_clk (conv_clk),
        .reset    (reset),
        .pins     (pins),
        .word     (word)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : give_verdict

    task automatic check(input logic [RES_W-1:0] got, input logic [RES_W-1:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    // host pins change only at the falling edge, well clear of the sampling edge
    task automatic drive(input logic mode, input logic hbs, input logic cs_n, input logic rd_n, input int cycles);
        @(negedge clk);
        host_pins = ahi_host_t'({mode, hbs, cs_n, rd_n});
        repeat (cycles) @(negedge clk);
    endtask : drive

    task automatic wait_busy(input logic level);
        int n;
        n = 0;
        while (busy !== level && n < 400) begin
            @(negedge clk);
            n++;
        end
        if (busy !== level) begin
            fails++;
            $display("ERROR at %0t: busy never reached %b", $time, level);
            give_verdict();
        end
    endtask : wait_busy

    // the serial clock is half the conversion clock rate, so 16 cycles see several edges
    task automatic count_toggles(output int cnt);
        logic last;
        cnt  = 0;
        last = pins.out[PIN_SCLK];
        repeat (16) begin
            @(negedge clk);
            if (pins.out[PIN_SCLK] !== last) cnt++;
            last = pins.out[PIN_SCLK];
        end
    endtask : count_toggles

    initial begin
        fails       = 0;
        check_count = 0;
        reset       = 1'b1;
        clk_en      = 1'b1;
        conv_sample = 12'hA5C;
        host_pins   = ahi_host_t'(4'hB);
        repeat (12) @(negedge clk);
        reset = 1'b0;
        check(result, RESULT_RST, "result after reset");
        check(RES_W'(pins.oe), 12'h000, "oe after reset");
        check(RES_W'(busy), 12'h000, "busy after reset");
        repeat (5) @(negedge clk);

        drive(1'b1, 1'b0, 1'b1, 1'b0, 6);
        check(RES_W'(busy), 12'h000, "read ignored without select");
        check(RES_W'(pins.oe), 12'h000, "pins float without select");
        drive(1'b1, 1'b0, 1'b0, 1'b0, 0);
        wait_busy(1'b1);
        check(RES_W'(pins.oe), RES_W'(OE_ALL), "parallel drive");
        wait_busy(1'b0);
        repeat (3) @(negedge clk);
        check(result, 12'hA5C, "parallel result");
        check(RES_W'(pins.out), 12'h05C, "low byte");
        drive(1'b1, 1'b1, 1'b0, 1'b1, 4);
        check(RES_W'(pins.oe), 12'h000, "read high floats bus");
        drive(1'b1, 1'b1, 1'b0, 1'b0, 6);
        check(RES_W'(busy), 12'h000, "high byte blocks start");
        check(RES_W'(pins.out), 12'h00A, "high nibble");
        // enable low freezes the pin enables even though chip select rises
        clk_en = 1'b0;
        drive(1'b1, 1'b0, 1'b1, 1'b1, 6);
        check(RES_W'(pins.oe), RES_W'(OE_ALL), "frozen enables");
        clk_en = 1'b1;
        repeat (4) @(negedge clk);
        check(RES_W'(pins.oe), 12'h000, "enables clear after freeze");
        $display("test parallel done");

        conv_sample = 12'h3C9;
        drive(1'b0, 1'b0, 1'b1, 1'b0, 6);
        check(RES_W'(pins.oe), 12'h000, "serial pins float");
        drive(1'b0, 1'b1, 1'b0, 1'b0, 4);
        check(RES_W'(pins.oe), RES_W'(OE_SERIAL), "serial drive");
        count_toggles(edges);
        check(RES_W'(edges >= 10), 12'h001, "free running serial clock");
        check(RES_W'(busy), 12'h000, "serial start blocked");
        drive(1'b0, 1'b1, 1'b0, 1'b1, 6);
        check(RES_W'(pins.oe), RES_W'(OE_SDOUT), "read high floats");
        drive(1'b0, 1'b0, 1'b1, 1'b0, 6);
        drive(1'b0, 1'b0, 1'b0, 1'b0, 0);
        wait_busy(1'b1);
        wait_busy(1'b0);
        repeat (4) @(negedge clk);
        check(word, 12'h3C9, "serial word");
        check(result, 12'h3C9, "serial result");
        count_toggles(edges);
        check(RES_W'(edges), 12'h000, "serial clock idle");
        $display("test serial done");
        give_verdict();
    end
endmodule : tb_adc_host_interface
